// [common/pwt_cfg.svh]
// constants shared by the modulator block and its timer controller
`ifndef PWT_CFG_SVH
`define PWT_CFG_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define PWT_NMOD      4
`define PWT_NTMR      3

// ----------------------------------------------------------------------
// modulator register map: address = {modulator, register}
// ----------------------------------------------------------------------
`define PWT_REG_CTRL  2'h0
`define PWT_REG_DCH   2'h1
`define PWT_REG_DCL   2'h2
`define PWT_REG_SEL   2'h3
`define PWT_EN_BIT    7
`define PWT_OUT_BIT   5
`define PWT_POL_BIT   4
`define PWT_SEL_RST   8'h55
`define PWT_TSEL_NONE 2'h0
`define PWT_SUB_MAX   2'h3

// ----------------------------------------------------------------------
// controller wishbone map
// ----------------------------------------------------------------------
`define PWT_WB_CTRL   8'h00
`define PWT_WB_SETUP  8'h04
`define PWT_WB_DUTY   8'h08
`define PWT_WB_TSEL   8'h0c
`define PWT_WB_STAT   8'h10
`define PWT_WB_CTRL_M 32'h0000_0002
`define PWT_WB_SET_M  32'h0000_0fff
`define PWT_WB_DUT_M  32'h00ff_0fff
`define PWT_WB_SEL_M  32'h0000_00ff
`define PWT_CTL_START 0
`define PWT_CTL_WAIT  1
`define PWT_CTL_STOP  2

`endif

// [common/pwt_pkg.sv]
// types shared by the modulator block and its timer controller
package pwt_pkg;
	typedef logic [2:0][7:0] pwt_t8_t;
	typedef logic [2:0][1:0] pwt_t2_t;
	typedef enum logic [3:0] {
		PWT_S_IDLE,
		PWT_S_PIN,
		PWT_S_CLR,
		PWT_S_SEL,
		PWT_S_PER,
		PWT_S_DCH,
		PWT_S_DCL,
		PWT_S_TMR,
		PWT_S_WAIT,
		PWT_S_CTRL
	} pwt_state_t;
endpackage : pwt_pkg

// [common/pwt_if.sv]
// link between the modulator block and the timer controller
`timescale 1ns/1ps
interface pwt_if;
	import pwt_pkg::*;
	logic [3:0] reg_addr;
	logic       reg_we;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	pwt_t8_t    tmr_count;
	pwt_t2_t    tmr_sub;
	pwt_t8_t    tmr_period;
	logic [2:0] tmr_wrap;

	modport dev (
		input  reg_addr,
		input  reg_we,
		input  reg_wdata,
		input  tmr_count,
		input  tmr_sub,
		input  tmr_period,
		input  tmr_wrap,
		output reg_rdata
	);

	modport ctl (
		output reg_addr,
		output reg_we,
		output reg_wdata,
		output tmr_count,
		output tmr_sub,
		output tmr_period,
		output tmr_wrap,
		input  reg_rdata
	);
endinterface : pwt_if

// [logic/pwt_mod_dev.sv]
// four 10-bit pulse-width modulators with their control registers
`timescale 1ns/1ps
`include "pwt_cfg.svh"

// How it works
// R1 - enable bit seven runs the modulator
// R2 - output-level bit five reads present output
// R3 - polarity bit four inverts the output
// R4 - unimplemented bits ignore writes, read zero
// R5 - select codes 01/10/11 pick timers 1-3
// R6 - selector fields per modulator, reset 01
// R7 - high duty register holds duty bits 9:2
// R8 - low duty register bits 7:6 hold 1:0
// R9 - duty registers unknown at power-up, kept
// R10 - control bits clear on every reset
// R11 - software clears control, loads period, duty
// R12 - software configures timer then starts it
// R13 - software waits overflow, loads control last
// R14 - overflow wait may be skipped
// R15 - set on timer clear, clear on match
// R16 - duty at or above period: never clears
// R17 - working duty loads at timer wrap only
// R18 - timebase is count plus two sub bits
// R19 - disabled output holds inactive polarity level
module pwt_mod_dev
	import pwt_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// link to the timers and the register master
	pwt_if.dev              lnk,
	// modulator outputs to peripherals
	output logic [3:0]      pwm_o
);

	localparam int NMOD = `PWT_NMOD;

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [NMOD-1:0] en;
	logic [NMOD-1:0] output_invert;
	logic [7:0]      dch [NMOD];
	logic [1:0]      dcl [NMOD];
	logic [7:0]      tsel;
	logic [7:0]      rdata;
	logic [NMOD-1:0] out_q;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic [1:0] a_mod;
	logic [1:0] a_reg;
	logic       wr_ctrl;
	logic       wr_dch;
	logic       wr_dcl;
	logic       wr_sel;

	assign a_mod   = lnk.reg_addr[3:2];
	assign a_reg   = lnk.reg_addr[1:0];
	assign wr_ctrl = lnk.reg_we && (a_reg == `PWT_REG_CTRL);
	assign wr_dch  = lnk.reg_we && (a_reg == `PWT_REG_DCH);
	assign wr_dcl  = lnk.reg_we && (a_reg == `PWT_REG_DCL);
	assign wr_sel  = lnk.reg_we && (a_reg == `PWT_REG_SEL);

	// ------------------------------------------------------------------
	// control register
	// ------------------------------------------------------------------
	// output-level bit is not stored; writes to it fall away
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en  <= '0; // R10
			output_invert <= '0; // R10
		end else if (wr_ctrl) begin
			en[a_mod]  <= lnk.reg_wdata[`PWT_EN_BIT]; // R1
			output_invert[a_mod] <= lnk.reg_wdata[`PWT_POL_BIT]; // R3
		end
	end

	// ------------------------------------------------------------------
	// timer selector
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tsel <= `PWT_SEL_RST; // R6
		end else if (wr_sel) begin
			tsel <= lnk.reg_wdata; // R6
		end
	end

	// ------------------------------------------------------------------
	// duty registers
	// ------------------------------------------------------------------
	// no reset on purpose: contents survive a warm reset
	always_ff @(posedge clk_i) begin
		if (wr_dch) begin
			dch[a_mod] <= lnk.reg_wdata; // R7 R9
		end
		if (wr_dcl) begin
			dcl[a_mod] <= lnk.reg_wdata[7:6]; // R8 R9
		end
	end

	// ------------------------------------------------------------------
	// read back, one cycle after the address
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata <= 8'h00;
		end else begin
			case (a_reg)
				`PWT_REG_CTRL: begin
					rdata <= {en[a_mod], 1'b0, out_q[a_mod],
						output_invert[a_mod], 4'h0}; // R2 R4
				end
				`PWT_REG_DCH: begin
					rdata <= dch[a_mod]; // R7
				end
				`PWT_REG_DCL: begin
					rdata <= {dcl[a_mod], 6'h00}; // R4 R8
				end
				default: begin
					rdata <= tsel; // R6
				end
			endcase
		end
	end

	assign lnk.reg_rdata = rdata;

	// ------------------------------------------------------------------
	// modulators
	// ------------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < NMOD; m = m + 1) begin : g_mod
			logic [1:0] code;
			logic [1:0] idx;
			logic       hit;
			logic       wrap;
			logic [9:0] tbase;
			logic [7:0] per;
			logic [9:0] work;
			logic [9:0] fresh;
			logic       full;
			logic       raw;
			logic       lvl;

			assign code  = tsel[2*m +: 2];
			// reserved code leaves the modulator without a time base
			assign hit   = (code != `PWT_TSEL_NONE); // R5
			assign idx   = code - 2'h1; // R5
			assign wrap  = hit && lnk.tmr_wrap[idx];
			assign tbase = {lnk.tmr_count[idx], lnk.tmr_sub[idx]}; // R18
			assign per   = lnk.tmr_period[idx];
			assign fresh = {dch[m], dcl[m]};
			assign full  = (work[9:2] >= per); // R16

			// buffer keeps a mid-period write from tearing the pulse
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					work <= 10'h000;
				end else if (wrap) begin
					work <= fresh; // R17
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					raw <= 1'b0;
				end else if (!en[m]) begin
					raw <= 1'b0; // R1
				end else if (wrap) begin
					raw <= (fresh != 10'h000); // R15 R16
				end else if (!full && (tbase == work)) begin
					raw <= 1'b0; // R15
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					lvl <= 1'b0;
				end else if (en[m]) begin
					lvl <= raw ^ output_invert[m]; // R3
				end else begin
					lvl <= output_invert[m]; // R19
				end
			end

			assign out_q[m] = lvl;
			assign pwm_o[m] = out_q[m];
		end
	endgenerate

endmodule : pwt_mod_dev

// [logic/pwt_tmr_ctl.sv]
// three period timers and a setup sequencer behind a wishbone slave
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pwt_cfg.svh"

module pwt_tmr_ctl
	import pwt_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// pin driver control, high keeps the pin driver off
	output logic             pin_direction_bit_o,
	// link to the modulators
	pwt_if.ctl               lnk
);

	// ------------------------------------------------------------------
	// wishbone registers
	// ------------------------------------------------------------------
	logic [31:0] r_ctrl;
	logic [31:0] r_set;
	logic [31:0] r_duty;
	logic [31:0] r_tsel;
	logic [31:0] wmask;
	logic        req;
	logic        wr;
	logic        start;
	logic        stop;
	logic        busy;
	logic [2:0]  ovf;
	pwt_state_t  state;

	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// writes land at the edge where the master sees ack high
	assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign busy  = (state != PWT_S_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			case (wb_adr_i)
				`PWT_WB_CTRL:  wb_dat_o <= r_ctrl;
				`PWT_WB_SETUP: wb_dat_o <= r_set;
				`PWT_WB_DUTY:  wb_dat_o <= r_duty;
				`PWT_WB_TSEL:  wb_dat_o <= r_tsel;
				`PWT_WB_STAT:  wb_dat_o <= {28'h0, ovf, busy};
				default:       wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_ctrl <= 32'h0000_0000;
			r_set  <= 32'h0000_0000;
			r_duty <= 32'h0000_0000;
			r_tsel <= 32'h0000_0000;
			start  <= 1'b0;
			stop   <= 1'b0;
		end else begin
			start <= wr && (wb_adr_i == `PWT_WB_CTRL) && wb_sel_i[0]
				&& wb_dat_i[`PWT_CTL_START];
			stop  <= wr && (wb_adr_i == `PWT_WB_CTRL) && wb_sel_i[0]
				&& wb_dat_i[`PWT_CTL_STOP];
			if (wr) begin
				case (wb_adr_i)
					`PWT_WB_CTRL: r_ctrl <= ((r_ctrl & ~wmask)
						| (wb_dat_i & wmask)) & `PWT_WB_CTRL_M;
					`PWT_WB_SETUP: r_set <= ((r_set & ~wmask)
						| (wb_dat_i & wmask)) & `PWT_WB_SET_M;
					`PWT_WB_DUTY: r_duty <= ((r_duty & ~wmask)
						| (wb_dat_i & wmask)) & `PWT_WB_DUT_M;
					`PWT_WB_TSEL: r_tsel <= ((r_tsel & ~wmask)
						| (wb_dat_i & wmask)) & `PWT_WB_SEL_M;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// setup sequencer
	// ------------------------------------------------------------------
	logic [1:0] t_idx;
	logic [1:0] m_idx;

	assign t_idx = r_set[11:10];
	assign m_idx = r_duty[11:10];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state               <= PWT_S_IDLE;
			lnk.reg_we          <= 1'b0;
			lnk.reg_addr        <= 4'h0;
			lnk.reg_wdata       <= 8'h00;
			pin_direction_bit_o <= 1'b1;
		end else begin
			lnk.reg_we <= 1'b0;
			case (state)
				PWT_S_IDLE: if (start) state <= PWT_S_PIN;
				PWT_S_PIN: begin
					pin_direction_bit_o <= 1'b1; // R11
					state <= PWT_S_CLR;
				end
				PWT_S_CLR: begin
					lnk.reg_we    <= 1'b1;
					lnk.reg_addr  <= {m_idx, `PWT_REG_CTRL};
					lnk.reg_wdata <= 8'h00; // R11
					state <= PWT_S_SEL;
				end
				PWT_S_SEL: begin
					lnk.reg_we    <= 1'b1;
					lnk.reg_addr  <= {m_idx, `PWT_REG_SEL};
					lnk.reg_wdata <= r_tsel[7:0];
					state <= PWT_S_PER;
				end
				PWT_S_PER: state <= PWT_S_DCH; // R11
				PWT_S_DCH: begin
					lnk.reg_we    <= 1'b1;
					lnk.reg_addr  <= {m_idx, `PWT_REG_DCH};
					lnk.reg_wdata <= r_duty[9:2]; // R11
					state <= PWT_S_DCL;
				end
				PWT_S_DCL: begin
					lnk.reg_we    <= 1'b1;
					lnk.reg_addr  <= {m_idx, `PWT_REG_DCL};
					lnk.reg_wdata <= {r_duty[1:0], 6'h00}; // R11
					state <= PWT_S_TMR;
				end
				PWT_S_TMR: state <= r_ctrl[`PWT_CTL_WAIT]
					? PWT_S_WAIT : PWT_S_CTRL; // R12 R14
				PWT_S_WAIT: if (ovf[t_idx]) state <= PWT_S_CTRL; // R13
				PWT_S_CTRL: begin
					lnk.reg_we    <= 1'b1;
					lnk.reg_addr  <= {m_idx, `PWT_REG_CTRL};
					lnk.reg_wdata <= r_duty[23:16]; // R13
					state <= PWT_S_IDLE;
				end
				default: state <= PWT_S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// timers, count clocked at a quarter of the prescaled clock (system clock divided by 1, 4, 16 or 64) via sub bits
	// ------------------------------------------------------------------
	genvar t;
	generate
		for (t = 0; t < `PWT_NTMR; t = t + 1) begin : g_tmr
			logic [7:0] per;
			logic [1:0] ps;
			logic       on;
			logic [5:0] pre;
			logic [5:0] pre_max;
			logic [1:0] sub;
			logic [7:0] cnt;
			logic       wrap;
			logic       tick;
			logic       me;
			logic       ovf_q;

			assign me   = (t_idx == 2'(t));
			assign tick = on && (pre == pre_max);
			always_comb begin
				case (ps)
					2'h0:    pre_max = 6'h00;
					2'h1:    pre_max = 6'h03;
					2'h2:    pre_max = 6'h0f;
					default: pre_max = 6'h3f;
				endcase
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					per <= 8'hff;
					ps  <= 2'h0;
					on  <= 1'b0;
				end else if (stop) begin
					on <= 1'b0;
				end else if (me && state == PWT_S_PER) begin
					per <= r_set[7:0]; // R11
				end else if (me && state == PWT_S_TMR) begin
					ps <= r_set[9:8]; // R12
					on <= 1'b1; // R12
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pre  <= 6'h00;
					sub  <= 2'h0;
					cnt  <= 8'h00;
					wrap <= 1'b0;
				end else begin
					wrap <= 1'b0;
					if (!on) begin
						pre <= 6'h00;
					end else if (tick) begin
						pre <= 6'h00;
						sub <= sub + 2'h1;
						if (sub == `PWT_SUB_MAX) begin
							if (cnt == per) begin
								cnt  <= 8'h00;
								wrap <= 1'b1;
							end else begin
								cnt <= cnt + 8'h01;
							end
						end
					end else begin
						pre <= pre + 6'h01;
					end
				end
			end

			// set wins over the sequencer's clear
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ovf_q <= 1'b0;
				end else if (wrap) begin
					ovf_q <= 1'b1;
				end else if (me && state == PWT_S_TMR) begin
					ovf_q <= 1'b0; // R12
				end
			end

			assign ovf[t]            = ovf_q;
			assign lnk.tmr_count[t]  = cnt;
			assign lnk.tmr_sub[t]    = sub;
			assign lnk.tmr_period[t] = per;
			assign lnk.tmr_wrap[t]   = wrap;
		end
	endgenerate

endmodule : pwt_tmr_ctl

// [tb/pwt_chk.sv]
// assertions on the modulator link and outputs
`timescale 1ns/1ps
`include "pwt_cfg.svh"

module pwt_chk
	import pwt_pkg::*;
(
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// link signals
	input wire logic [3:0] reg_addr,
	input wire logic       reg_we,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire pwt_t8_t    tmr_count,
	input wire pwt_t2_t    tmr_sub,
	input wire pwt_t8_t    tmr_period,
	input wire logic [2:0] tmr_wrap,
	// modulator outputs
	input wire logic [3:0] pwm_o
);
	// ----------------------------------------------------------------
	// register shadows
	// ----------------------------------------------------------------
	logic [3:0]      en;
	logic [3:0]      output_invert;
	logic [7:0]      sel;
	logic [3:0][9:0] dsh;
	wire logic [1:0] ra = reg_addr[1:0];
	wire logic [1:0] rm = reg_addr[3:2];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en  <= 4'h0;
			output_invert <= 4'h0;
		end else if (reg_we && ra == `PWT_REG_CTRL) begin
			en[rm]  <= reg_wdata[`PWT_EN_BIT];
			output_invert[rm] <= reg_wdata[`PWT_POL_BIT];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sel <= `PWT_SEL_RST;
		else if (reg_we && ra == `PWT_REG_SEL)
			sel <= reg_wdata;
	end
	// no reset here: duty survives resets, unknown until written
	always_ff @(posedge clk_i) begin
		if (reg_we && ra == `PWT_REG_DCH)
			dsh[rm][9:2] <= reg_wdata;
		if (reg_we && ra == `PWT_REG_DCL)
			dsh[rm][1:0] <= reg_wdata[7:6];
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_rst;
		$fell(rst_i) |-> pwm_o == 4'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");
	property p_ctl;
		ra == `PWT_REG_CTRL |=> reg_rdata ==
			$past({en[rm], 1'b0, pwm_o[rm], output_invert[rm], 4'h0});
	endproperty
	a_ctl: assert property (p_ctl)
		else $error("control readback wrong");
	property p_dcl;
		ra == `PWT_REG_DCL |=> reg_rdata[5:0] == 6'h0;
	endproperty
	a_dcl: assert property (p_dcl)
		else $error("duty low unused bits not zero");
	property p_dcv;
		ra == `PWT_REG_DCL && !reg_we |=>
			reg_rdata == {$past(dsh[rm][1:0]), 6'h00};
	endproperty
	a_dcv: assert property (p_dcv)
		else $error("duty low readback wrong");
	property p_sel;
		ra == `PWT_REG_SEL |=> reg_rdata == $past(sel);
	endproperty
	a_sel: assert property (p_sel)
		else $error("selector readback wrong");

	for (genvar m = 0; m < `PWT_NMOD; m++) begin : g_mod
		logic [1:0] ts;
		logic [1:0] ti;
		logic       wrp;
		logic       full;
		logic [9:0] wd;
		assign ts   = sel[2*m +: 2];
		assign ti   = ts - 2'h1;
		assign wrp  = ts != `PWT_TSEL_NONE && tmr_wrap[ti];
		assign full = wd[9:2] >= tmr_period[ti];
		// working copy follows the wrap of the selected timer only
		always_ff @(posedge clk_i) begin
			if (rst_i)
				wd <= 10'h0;
			else if (wrp)
				wd <= dsh[m];
		end
		property p_off;
			!en[m] |=> pwm_o[m] == $past(output_invert[m]);
		endproperty
		a_off: assert property (p_off)
			else $error("disabled output not at polarity");
		property p_set;
			en[m] && wrp && dsh[m] != 10'h0 ##1 en[m]
				|=> pwm_o[m] != $past(output_invert[m]);
		endproperty
		a_set: assert property (p_set)
			else $error("output not set at wrap");
		property p_clr;
			en[m] && !wrp && !full && wd != 10'h0 &&
				{tmr_count[ti], tmr_sub[ti]} == wd ##1 en[m]
				|=> pwm_o[m] == $past(output_invert[m]);
		endproperty
		a_clr: assert property (p_clr)
			else $error("output not cleared at match");
		property p_full;
			en[m] && full && !wrp && wd != 10'h0 ##1
				en[m] && pwm_o[m] != $past(output_invert[m])
				|=> pwm_o[m] != $past(output_invert[m]);
		endproperty
		a_full: assert property (p_full)
			else $error("full duty output cleared");
	end
endmodule : pwt_chk

// [tb/testbench.sv]
// self-checking bench for modulators and timer controller
`timescale 1ns/1ps
`include "pwt_cfg.svh"

module testbench;
	import pwt_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic        wb_cyc_i    = 1'b0;
	logic        wb_stb_i    = 1'b0;
	logic        wb_we_i     = 1'b0;
	logic [7:0]  wb_adr_i    = 8'h00;
	logic [3:0]  wb_sel_i    = 4'h0;
	logic [31:0] wb_dat_i    = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin_dir;
	logic [3:0]  pwm_o;
	int          errors      = 0;
	int          check_count = 0;

	pwt_if lnk ();
	pwt_mod_dev u_pwt_mod_dev (.clk_i(clk_i), .rst_i(rst_i),
		.lnk(lnk), .pwm_o(pwm_o));
	pwt_tmr_ctl u_pwt_tmr_ctl (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pin_direction_bit_o(pin_dir), .lnk(lnk));
	pwt_chk u_pwt_chk (.clk_i(clk_i), .rst_i(rst_i),
		.reg_addr(lnk.reg_addr), .reg_we(lnk.reg_we),
		.reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
		.tmr_count(lnk.tmr_count), .tmr_sub(lnk.tmr_sub),
		.tmr_period(lnk.tmr_period), .tmr_wrap(lnk.tmr_wrap),
		.pwm_o(pwm_o));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) begin
			errors++;
			end_of_test();
		end
	endtask : wb
	// full software sequence, polled until the sequencer is idle
	task automatic setup(input logic [1:0] m, input logic [1:0] t,
		input logic [1:0] p, input logic [7:0] per, input logic [9:0] dc,
		input logic [7:0] cb, input logic [7:0] sl, input logic wt);
		logic [31:0] q;
		int          n;
		wb(1'b1, `PWT_WB_SETUP, {20'h0, t, p, per}, q);
		wb(1'b1, `PWT_WB_DUTY, {8'h0, cb, 4'h0, m, dc}, q);
		wb(1'b1, `PWT_WB_TSEL, {24'h0, sl}, q);
		wb(1'b1, `PWT_WB_CTRL, {30'h0, wt, 1'b1}, q);
		n = 0;
		do begin
			wb(1'b0, `PWT_WB_STAT, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		if (n >= 200) begin
			errors++;
			end_of_test();
		end
	endtask : setup
	// counting over whole periods makes the result phase independent
	task automatic ones(input int m, input int win, input int ex,
		input string nm);
		int c;
		c = 0;
		repeat (win) begin
			@(posedge clk_i);
			c += (pwm_o[m] === 1'b1);
		end
		chk(nm, ex, c);
	endtask : ones
	task automatic t_reset;
		logic [31:0] q;
		@(posedge clk_i);
		chk("pin_dir", 32'h1, {31'h0, pin_dir});
		chk("pwm", 32'h0, {28'h0, pwm_o});
		wb(1'b0, `PWT_WB_STAT, 32'h0, q);
		chk("stat", 32'h0, q);
		wb(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
	endtask : t_reset
	task automatic t_levels;
		logic [9:0] dc [6] = '{10'h009, 10'h009, 10'h014, 10'h000,
			10'h009, 10'h009};
		logic [7:0] cb [6] = '{8'h80, 8'h90, 8'h80, 8'h80, 8'h10, 8'h00};
		int         ex [6] = '{18, 22, 40, 0, 40, 0};
		for (int i = 0; i < 6; i++) begin
			setup(2'h0, 2'h0, 2'h0, 8'h04, dc[i], cb[i], `PWT_SEL_RST, 1'b1);
			repeat (40) @(posedge clk_i);
			ones(0, 40, ex[i], "mod0 high");
		end
	endtask : t_levels
	task automatic t_select;
		logic [31:0] q;
		logic        v;
		setup(2'h1, 2'h2, 2'h0, 8'h02, 10'h005, 8'h80, 8'h5d, 1'b1);
		setup(2'h2, 2'h1, 2'h1, 8'h01, 10'h003, 8'h80, 8'h6d, 1'b1);
		repeat (64) @(posedge clk_i);
		fork
			ones(1, 24, 10, "mod1 third timer");
			ones(2, 64, 24, "mod2 second timer");
		join
		wb(1'b0, `PWT_WB_SETUP, 32'h0, q);
		chk("setup reg", 32'h0000_0501, q);
		wb(1'b0, `PWT_WB_DUTY, 32'h0, q);
		chk("duty reg", 32'h0080_0803, q);
		wb(1'b0, `PWT_WB_TSEL, 32'h0, q);
		chk("tsel reg", 32'h0000_006d, q);
		wb(1'b0, `PWT_WB_CTRL, 32'h0, q);
		chk("ctrl reg", 32'h0000_0002, q);
		wb(1'b0, `PWT_WB_STAT, 32'h0, q);
		chk("stat ovf", 32'h0000_000e, q);
		// stopped timers give no more events: output freezes
		wb(1'b1, `PWT_WB_CTRL, 32'h0000_0004, q);
		repeat (4) @(posedge clk_i);
		v = pwm_o[1];
		ones(1, 24, v ? 24 : 0, "mod1 frozen");
	endtask : t_select
	task automatic t_rerst;
		setup(2'h3, 2'h0, 2'h0, 8'h04, 10'h009, 8'h10, 8'h6d, 1'b0);
		repeat (4) @(posedge clk_i);
		chk("mod3 idle", 32'h1, {31'h0, pwm_o[3]});
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pwm after reset", 32'h0, {28'h0, pwm_o});
	endtask : t_rerst
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial forever #25 clk_i = ~clk_i;
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_levels();
		t_select();
		t_rerst();
		end_of_test();
	end
endmodule : testbench
